/* File: rtl/dsdc_pkg.sv */
// Constants, types and register map of the spread-spectrum demodulator control and status bank.
// Assumes a 32-bit APB register port and a datapath that supplies status values on the system clock.
// Overview of operation
// - Frequency acquisition field: 00 automatic, 01 forced off, 10 forced on, 11 test.
// - In automatic mode the wideband frequency loop turns off once acquisition completes.
// - With the frequency loop off, only the carrier tracking loop acquires carrier.
// - Decoding field: 00 binary, 01 quadrature, upper bit set forces continuous code search.
// - Sweep field sets dwell per code position to 8 times two to the field bits.
// - Writing one to software reset sends all loops to acquisition; bit self-clears.
// - Output 000 sends samples to parallel connector, I then Q serialized for quadrature.
// - Output 001 sends I and Q in parallel on separate connector ports.
// - Output 010 packs one-bit hard decisions eight per byte, MSB first, to USB.
// - Output 011 packs four-bit soft values two per byte to USB.
// - Gain output updates once every two-to-the-field input chips, field 0 to 22.
// - Carrier offset reported as 32-bit signed value over four bytes, LSB first.
// - Front-end gain reported as an 8-bit unsigned status byte.
// - Lock status byte: bit 0 carrier lock, bit 1 code lock, one when locked.
// - Signal power reported as 23-bit value over three bytes, LSB first.
// - Noise power over 512 symbols reported as 23-bit value over three bytes.
// - Capture monitor rate set by a decimation factor or the processing clock.
// - Code lock probe is high when locked, low while scanning.
// - Power probe is high while despread power exceeds detection threshold.
// - Code lock missing for sweep period bits starts a one-chip-per-period slide.
// - All processing and offset scaling run from the single processing clock.
package dsdc_pkg;
  // Register word indexes (byte address is four times the index)
  localparam logic [4:0] IDX_AFC_CTRL = 5'h00;
  localparam logic [4:0] IDX_DECODE_CTRL = 5'h01;
  localparam logic [4:0] IDX_OUTSEL_CTRL = 5'h02;
  localparam logic [4:0] IDX_GAINRATE_CTRL = 5'h03;
  localparam logic [4:0] IDX_CAPTURE_CTRL = 5'h04;
  localparam logic [4:0] IDX_FREQ_B0 = 5'h08;
  localparam logic [4:0] IDX_FREQ_B1 = 5'h09;
  localparam logic [4:0] IDX_FREQ_B2 = 5'h0A;
  localparam logic [4:0] IDX_FREQ_B3 = 5'h0B;
  localparam logic [4:0] IDX_GAIN_STAT = 5'h0C;
  localparam logic [4:0] IDX_LOCK_STAT = 5'h0D;
  localparam logic [4:0] IDX_SIG_B0 = 5'h0E;
  localparam logic [4:0] IDX_SIG_B1 = 5'h0F;
  localparam logic [4:0] IDX_SIG_B2 = 5'h10;
  localparam logic [4:0] IDX_NOISE_B0 = 5'h11;
  localparam logic [4:0] IDX_NOISE_B1 = 5'h12;
  localparam logic [4:0] IDX_NOISE_B2 = 5'h13;
  // Field positions
  localparam int AFC_LSB = 6;
  localparam int DEC_LSB = 2;
  localparam int SWEEP_LSB = 4;
  localparam int SWRST_BIT = 7;
  localparam int OUTSEL_LSB = 0;
  localparam int GAINRATE_LSB = 0;
  localparam int CAP_DECIM_LSB = 0;
  localparam int CAP_FCLK_BIT = 7;
  // Reset values
  localparam logic [7:0] AFC_CTRL_RST = 8'h00;
  localparam logic [7:0] DECODE_CTRL_RST = 8'h00;
  localparam logic [7:0] OUTSEL_CTRL_RST = 8'h00;
  localparam logic [7:0] GAINRATE_CTRL_RST = 8'h10;
  localparam logic [7:0] CAPTURE_CTRL_RST = 8'h00;
  // Limits
  localparam logic [4:0] GAINRATE_MAX = 5'h16;
  localparam logic [2:0] SWEEP_MAX = 3'h6;
  localparam logic [3:0] SWEEP_BASE_LOG2 = 4'h3;
  localparam int NOISE_SYMBOLS = 512;
  localparam int PROC_CLK_HZ = 90000000;

  typedef enum logic [1:0] {AFC_AUTO = 2'h0, AFC_OFF = 2'h1, AFC_ON = 2'h2, AFC_TEST = 2'h3} dsdc_afc_t;
  typedef enum logic [2:0] {OUT_SERIAL = 3'h0, OUT_PARALLEL = 3'h1, OUT_USB_HARD = 3'h2,
                            OUT_USB_SOFT = 3'h3} dsdc_out_t;

  // Status sample from the datapath
  typedef struct packed {
    logic [31:0] freqOffset;
    logic [7:0] gain;
    logic carrierLock;
    logic codeLock;
    logic [22:0] sigPower;
    logic [22:0] noisePower;
  } dsdc_status_t;

  // Control word delivered to the datapath
  typedef struct packed {
    logic afcEnable;
    logic quadrature;
    logic forcedSearch;
    logic [9:0] sweepBits;
    logic loopReset;
    logic [2:0] outSel;
    logic [4:0] gainRate;
    logic [6:0] capDecim;
    logic capUseFclk;
  } dsdc_ctrl_t;
endpackage : dsdc_pkg

/* File: rtl/dsdc_sample_pack.sv */
// Packs demodulated hard or soft decisions into bytes for the USB path.
// Assumes one-cycle sample strobes on the system clock and a sink that takes bytes as they come.
`timescale 1ns/10ps
`default_nettype none
module dsdc_sample_pack
  import dsdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic softMode,
  input wire logic flush,
  input wire logic sampleValid,
  input wire logic [3:0] sampleI,
  output logic [7:0] byteData,
  output logic byteValid
);
  logic [7:0] shiftReg;
  logic [2:0] countReg;
  logic [2:0] lastCount;

  // Hard mode fills eight single bits, soft mode two nibbles
  assign lastCount = softMode ? 3'h1 : 3'h7;

  // Shift in, MSB first, emit on the last slot
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shiftReg <= 8'h00;
      countReg <= 3'h0;
      byteData <= 8'h00;
      byteValid <= 1'b0;
    end else begin
      byteValid <= 1'b0;
      if (flush) begin
        countReg <= 3'h0;
      end else if (sampleValid) begin
        if (softMode) begin
          shiftReg <= {shiftReg[3:0], sampleI};
        end else begin
          shiftReg <= {shiftReg[6:0], sampleI[3]};
        end
        if (countReg == lastCount) begin
          countReg <= 3'h0;
          byteValid <= 1'b1;
          byteData <= softMode ? {shiftReg[3:0], sampleI} : {shiftReg[6:0], sampleI[3]};
        end else begin
          countReg <= countReg + 3'h1;
        end
      end
    end
  end

  // Eighth hard bit lands in bit 0, so the first bit sits in the MSB
  hard_pack_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (sampleValid && !flush && !softMode && countReg == 3'h7) |=> byteValid)
    else $error("hard byte not emitted after eighth bit");
  soft_pack_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (sampleValid && !flush && softMode && countReg == 3'h1) |=> (byteValid && byteData[3:0] == $past(sampleI)))
    else $error("soft byte low nibble wrong");
endmodule : dsdc_sample_pack
`default_nettype wire

/* File: rtl/dsdc_regbank.sv */
// Control and status register bank of the spread-spectrum demodulator, APB slave.
// Assumes APB master on clk_sys; status inputs and lock signals come from the same clock domain.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dsdc_regbank
  import dsdc_pkg::*;
#(
  parameter int GAIN_RATE_MAX = 22
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsdc_pkg::dsdc_status_t statusIn,
  input wire logic despreadPower,
  input wire logic detectThreshold,
  input wire logic chipStrobe,
  input wire logic bitStrobe,
  input wire logic acqDone,
  input wire logic demodValid,
  input wire logic [3:0] demodI,
  input wire logic [3:0] demodQ,
  output dsdc_pkg::dsdc_ctrl_t ctrlOut,
  output logic codeSlide,
  output logic gainUpdate,
  output logic captureStrobe,
  output logic [3:0] connDataI,
  output logic [3:0] connDataQ,
  output logic connValid,
  output logic [7:0] usbData,
  output logic usbValid,
  output logic code_lock_probe,
  output logic power_above_threshold_probe
);
  import dsdc_pkg::*;

  logic [7:0] afcCtrl_reg;
  logic [7:0] decodeCtrl_reg;
  logic [7:0] outSelCtrl_reg;
  logic [7:0] gainRateCtrl_reg;
  logic [7:0] captureCtrl_reg;
  logic loopReset_reg;
  logic acquiring_reg;
  dsdc_status_t hold_reg;
  logic [9:0] missCount_reg;
  logic [22:0] chipCount_reg;
  logic [6:0] decimCount_reg;
  logic serialQ_reg;
  logic [3:0] pendQ_reg;
  logic wrEn;
  logic rdEn;
  logic [4:0] idx;
  logic mapped;
  logic [2:0] sweepField;
  logic [9:0] sweepBits;
  logic [1:0] afcField;
  logic [1:0] decField;
  logic [4:0] rateField;
  logic [22:0] rateMask;
  logic packFlush;

  // Word index of an aligned address; misaligned or out-of-range decodes as unmapped
  function automatic logic isMapped(input logic [11:0] a);
    logic [4:0] i;
    i = a[6:2];
    isMapped = (a[1:0] == 2'h0) && (a[11:7] == 5'h00) && ((i <= IDX_CAPTURE_CTRL) ||
               (i >= IDX_FREQ_B0 && i <= IDX_NOISE_B2));
  endfunction : isMapped

  // Bus decode; every access completes in its first access cycle
  assign idx = paddr[6:2];
  assign mapped = isMapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wrEn = psel && penable && pwrite && mapped;
  assign rdEn = psel && !penable && !pwrite;

  // Control registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      afcCtrl_reg <= AFC_CTRL_RST;
      decodeCtrl_reg <= DECODE_CTRL_RST;
      outSelCtrl_reg <= OUTSEL_CTRL_RST;
      gainRateCtrl_reg <= GAINRATE_CTRL_RST;
      captureCtrl_reg <= CAPTURE_CTRL_RST;
    end else if (wrEn) begin
      unique case (idx)
        IDX_AFC_CTRL: afcCtrl_reg <= pwdata[7:0];
        IDX_DECODE_CTRL: decodeCtrl_reg <= {1'b0, pwdata[6:0]}; // Reset bit never stored
        IDX_OUTSEL_CTRL: outSelCtrl_reg <= pwdata[7:0];
        IDX_GAINRATE_CTRL: gainRateCtrl_reg <= pwdata[7:0];
        IDX_CAPTURE_CTRL: captureCtrl_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // One-shot loop reset pulse from the write of a one
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loopReset_reg <= 1'b0;
    end else begin
      loopReset_reg <= wrEn && idx == IDX_DECODE_CTRL && pwdata[SWRST_BIT];
    end
  end

  assign afcField = afcCtrl_reg[AFC_LSB +: 2];
  assign decField = decodeCtrl_reg[DEC_LSB +: 2];
  assign sweepField = decodeCtrl_reg[SWEEP_LSB +: 3];
  assign rateField = gainRateCtrl_reg[GAINRATE_LSB +: 5];

  // Sweep period in bits; unlisted code 111 clamps to the longest period
  assign sweepBits = 10'(1) << (SWEEP_BASE_LOG2 + ((sweepField > SWEEP_MAX) ? SWEEP_MAX : sweepField));

  // Acquisition tracking: loop reset or lost lock restarts it, datapath reports completion
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acquiring_reg <= 1'b1;
    end else if (loopReset_reg || codeSlide) begin
      acquiring_reg <= 1'b1;
    end else if (acqDone) begin
      acquiring_reg <= 1'b0;
    end
  end

  // Control word to the datapath
  always_comb begin
    ctrlOut.afcEnable = 1'b0;
    unique case (afcField)
      AFC_AUTO: ctrlOut.afcEnable = acquiring_reg;
      AFC_OFF: ctrlOut.afcEnable = 1'b0; // Carrier tracking loop only
      AFC_ON: ctrlOut.afcEnable = 1'b1;
      AFC_TEST: ctrlOut.afcEnable = 1'b1;
    endcase
    ctrlOut.quadrature = (decField == 2'h1);
    ctrlOut.forcedSearch = decField[1];
    ctrlOut.sweepBits = sweepBits;
    ctrlOut.loopReset = loopReset_reg;
    ctrlOut.outSel = outSelCtrl_reg[OUTSEL_LSB +: 3];
    ctrlOut.gainRate = rateField;
    ctrlOut.capDecim = captureCtrl_reg[CAP_DECIM_LSB +: 7];
    ctrlOut.capUseFclk = captureCtrl_reg[CAP_FCLK_BIT];
  end

  // Count bits without code lock; slide one chip per sweep period while unlocked
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      missCount_reg <= 10'h000;
      codeSlide <= 1'b0;
    end else begin
      codeSlide <= 1'b0;
      if ((statusIn.codeLock && !ctrlOut.forcedSearch) || loopReset_reg) begin
        missCount_reg <= 10'h000;
      end else if (bitStrobe) begin
        if (missCount_reg + 10'h001 >= sweepBits) begin
          missCount_reg <= 10'h000;
          codeSlide <= 1'b1;
        end else begin
          missCount_reg <= missCount_reg + 10'h001;
        end
      end
    end
  end

  // Gain update once every 2^N chips, field clamped to the valid range
  assign rateMask = (23'(1) << ((rateField > 5'(GAIN_RATE_MAX)) ? 5'(GAIN_RATE_MAX) : rateField)) - 23'h1;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chipCount_reg <= 23'h0;
      gainUpdate <= 1'b0;
    end else begin
      gainUpdate <= 1'b0;
      if (chipStrobe) begin
        if ((chipCount_reg & rateMask) == rateMask) begin
          chipCount_reg <= 23'h0;
          gainUpdate <= 1'b1;
        end else begin
          chipCount_reg <= chipCount_reg + 23'h1;
        end
      end
    end
  end

  // Capture strobe: every processing clock, or once every decimation count plus one symbols
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      decimCount_reg <= 7'h00;
      captureStrobe <= 1'b0;
    end else if (ctrlOut.capUseFclk) begin
      decimCount_reg <= 7'h00;
      captureStrobe <= 1'b1;
    end else begin
      captureStrobe <= 1'b0;
      if (demodValid) begin
        if (decimCount_reg >= ctrlOut.capDecim) begin
          decimCount_reg <= 7'h00;
          captureStrobe <= 1'b1;
        end else begin
          decimCount_reg <= decimCount_reg + 7'h01;
        end
      end
    end
  end

  // Parallel connector: serial mode sends I, then in quadrature Q next cycle, on the I port
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      connDataI <= 4'h0;
      connDataQ <= 4'h0;
      connValid <= 1'b0;
      serialQ_reg <= 1'b0;
      pendQ_reg <= 4'h0;
    end else begin
      connValid <= 1'b0;
      serialQ_reg <= 1'b0;
      if (ctrlOut.outSel == OUT_SERIAL && serialQ_reg) begin
        connDataI <= pendQ_reg;
        connValid <= 1'b1;
      end else if (demodValid && ctrlOut.outSel == OUT_SERIAL) begin
        connDataI <= demodI;
        connDataQ <= 4'h0;
        connValid <= 1'b1;
        serialQ_reg <= ctrlOut.quadrature;
        pendQ_reg <= demodQ;
      end else if (demodValid && ctrlOut.outSel == OUT_PARALLEL) begin
        connDataI <= demodI;
        connDataQ <= demodQ;
        connValid <= 1'b1;
      end
    end
  end

  // USB packing only in the two USB modes
  assign packFlush = !(ctrlOut.outSel == OUT_USB_HARD || ctrlOut.outSel == OUT_USB_SOFT) || loopReset_reg;
  dsdc_sample_pack uPack (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .softMode(ctrlOut.outSel == OUT_USB_SOFT),
    .flush(packFlush),
    .sampleValid(demodValid),
    .sampleI(demodI),
    .byteData(usbData),
    .byteValid(usbValid)
  );

  // Probes follow the lock and power comparison
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      code_lock_probe <= 1'b0;
      power_above_threshold_probe <= 1'b0;
    end else begin
      code_lock_probe <= statusIn.codeLock;
      power_above_threshold_probe <= despreadPower && detectThreshold;
    end
  end

  // Snapshot whole status at setup of a read of any first byte, so later bytes match
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hold_reg <= '0;
    end else if (rdEn && (idx == IDX_FREQ_B0 || idx == IDX_SIG_B0 || idx == IDX_NOISE_B0 ||
                          idx == IDX_GAIN_STAT || idx == IDX_LOCK_STAT)) begin
      hold_reg <= statusIn;
    end
  end

  // Read mux from the held sample; first byte also reads the snapshot taken at its own setup
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (idx)
      IDX_AFC_CTRL: prdata = {24'h0, afcCtrl_reg};
      IDX_DECODE_CTRL: prdata = {24'h0, decodeCtrl_reg};
      IDX_OUTSEL_CTRL: prdata = {24'h0, outSelCtrl_reg};
      IDX_GAINRATE_CTRL: prdata = {24'h0, gainRateCtrl_reg};
      IDX_CAPTURE_CTRL: prdata = {24'h0, captureCtrl_reg};
      IDX_FREQ_B0: prdata = {24'h0, hold_reg.freqOffset[7:0]};
      IDX_FREQ_B1: prdata = {24'h0, hold_reg.freqOffset[15:8]};
      IDX_FREQ_B2: prdata = {24'h0, hold_reg.freqOffset[23:16]};
      IDX_FREQ_B3: prdata = {24'h0, hold_reg.freqOffset[31:24]};
      IDX_GAIN_STAT: prdata = {24'h0, hold_reg.gain};
      IDX_LOCK_STAT: prdata = {30'h0, hold_reg.codeLock, hold_reg.carrierLock};
      IDX_SIG_B0: prdata = {24'h0, hold_reg.sigPower[7:0]};
      IDX_SIG_B1: prdata = {24'h0, hold_reg.sigPower[15:8]};
      IDX_SIG_B2: prdata = {25'h0, hold_reg.sigPower[22:16]};
      IDX_NOISE_B0: prdata = {24'h0, hold_reg.noisePower[7:0]};
      IDX_NOISE_B1: prdata = {24'h0, hold_reg.noisePower[15:8]};
      IDX_NOISE_B2: prdata = {25'h0, hold_reg.noisePower[22:16]};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Checks
  afc_forced_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (afcField == 2'h1) |-> !ctrlOut.afcEnable) else $error("frequency loop on while forced off");
  afc_auto_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (afcField == 2'h0 && acqDone && !loopReset_reg && !codeSlide) |=> !ctrlOut.afcEnable)
    else $error("automatic loop stayed on after acquisition");
  swreset_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wrEn && idx == IDX_DECODE_CTRL && pwdata[SWRST_BIT]) |=> (loopReset_reg ##1 !loopReset_reg [*2]))
    else $error("software reset not a one-shot");
  reset_bit_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !decodeCtrl_reg[SWRST_BIT]) else $error("reset bit stored");
  forced_search_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    decField[1] |-> ctrlOut.forcedSearch && !ctrlOut.quadrature) else $error("test decode mode wrong");
  sweep_len_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (sweepField == 3'h6) |-> (ctrlOut.sweepBits == 10'd512)) else $error("sweep period 110 not 512");
  gain_rate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rateField == 5'h0 && chipStrobe) |=> gainUpdate) else $error("gain not updated every chip");
  serial_q_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (demodValid && ctrlOut.outSel == OUT_SERIAL && ctrlOut.quadrature && !serialQ_reg) |=> connValid ##1
    (connValid && connDataI == $past(demodQ, 2))) else $error("Q did not follow I");
  lock_probe_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    code_lock_probe == $past(statusIn.codeLock)) else $error("code lock probe wrong");
  power_probe_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (despreadPower && detectThreshold) |=> power_above_threshold_probe) else $error("power probe low");
  cov_swreset_c: cover property (@(posedge clk_sys) disable iff (!nrst) loopReset_reg);
  cov_slide_c: cover property (@(posedge clk_sys) disable iff (!nrst) codeSlide);
  cov_usb_c: cover property (@(posedge clk_sys) disable iff (!nrst) usbValid);
  cov_err_c: cover property (@(posedge clk_sys) disable iff (!nrst) pslverr);
endmodule : dsdc_regbank
`default_nettype wire

/* File: dv/dsdc_front_model.sv */
// Front-end timing model: chip and bit strobes, counts gain and slide pulses.
// Assumes one system clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module dsdc_front_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic run,
  input wire logic gainUpdate,
  input wire logic codeSlide,
  output logic chipStrobe,
  output logic bitStrobe,
  output var int gainCount,
  output var int slideCount
);
  logic [1:0] chipPhase;
  // One chip a cycle while running, a bit every fourth chip
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chipPhase <= 2'h0;
      chipStrobe <= 1'b0;
      bitStrobe <= 1'b0;
    end else begin
      chipStrobe <= run;
      bitStrobe <= run && chipPhase == 2'h3;
      chipPhase <= chipPhase + 2'(run);
    end
  end
  // Counters, so rates are judged over whole runs, not edge by edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gainCount <= 0;
      slideCount <= 0;
    end else begin
      gainCount <= gainCount + int'(gainUpdate === 1'b1);
      slideCount <= slideCount + int'(codeSlide === 1'b1);
    end
  end
endmodule : dsdc_front_model
`default_nettype wire

/* File: dv/test_dsdc_regbank.sv */
// Self-checking bench for the demodulator register bank.
// Assumes an APB slave that answers in its own time and status inputs on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module test_dsdc_regbank;
  import dsdc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r, v;
  logic pready, pslverr, e, chipStrobe, bitStrobe, codeSlide, gainUpdate, connValid, usbValid;
  logic code_lock_probe, power_above_threshold_probe;
  dsdc_status_t st = '0;
  logic despreadPower = 1'b0;
  logic detectThreshold = 1'b0;
  logic acqDone = 1'b0;
  logic demodValid = 1'b0;
  logic run = 1'b0;
  logic [3:0] demodI = 4'h0;
  logic [3:0] demodQ = 4'h0;
  logic [3:0] connDataI, connDataQ;
  logic [7:0] usbData;
  logic [7:0] connQ[$];
  logic [7:0] usbQ[$];
  dsdc_ctrl_t ctrlOut;
  int gainCount, slideCount;
  int fail_count = 0;
  int tests_run = 0;
  int lrCount = 0;
  int capCount = 0;
  logic capStb;
  logic [11:0] base [5] = '{12'h020, 12'h030, 12'h034, 12'h038, 12'h044};
  int nb [5] = '{4, 1, 1, 3, 3};

  dsdc_regbank i_dsdc_regbank (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .statusIn(st), .despreadPower, .detectThreshold, .chipStrobe, .bitStrobe, .acqDone, .demodValid,
    .demodI, .demodQ, .ctrlOut, .codeSlide, .gainUpdate, .captureStrobe(capStb), .connDataI, .connDataQ, .connValid,
    .usbData, .usbValid, .code_lock_probe, .power_above_threshold_probe);
  dsdc_front_model i_dsdc_front_model (.clk_sys, .nrst, .run, .gainUpdate, .codeSlide, .chipStrobe,
    .bitStrobe, .gainCount, .slideCount);

  always #10 clk_sys = ~clk_sys;

  // Words leaving the connector and USB paths, and one-shot pulses
  always @(posedge clk_sys) begin
    if (connValid === 1'b1)
      connQ.push_back({connDataQ, connDataI});
    if (usbValid === 1'b1)
      usbQ.push_back(usbData);
    if (ctrlOut.loopReset === 1'b1)
      lrCount++;
    if (capStb === 1'b1)
      capCount++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd

  task automatic send(input logic [3:0] i, input logic [3:0] q);
    demodValid <= 1'b1;
    demodI <= i;
    demodQ <= q;
    @(posedge clk_sys);
    demodValid <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : send

  function automatic logic [31:0] grp(input dsdc_status_t s, input int g);
    case (g)
      0: return s.freqOffset;
      1: return {24'h0, s.gain};
      2: return {30'h0, s.codeLock, s.carrierLock};
      3: return {9'h0, s.sigPower};
      default: return {9'h0, s.noisePower};
    endcase
  endfunction : grp

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    dsdc_status_t old;
    int capBase;
    r = $urandom(32'h193D);
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h00C, 32'h10);
    chk(ctrlOut.afcEnable, 1'b1);
    acqDone <= 1'b1;
    @(posedge clk_sys);
    acqDone <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(ctrlOut.afcEnable, 1'b0);
    wr(12'h004, 32'h80);
    repeat (2) @(posedge clk_sys);
    chk(lrCount, 1);
    chk(ctrlOut.afcEnable, 1'b1);
    rd(12'h004, 32'h0);
    for (int c = 1; c < 4; c++) begin
      wr(12'h000, 32'(c << 6));
      chk(ctrlOut.afcEnable, c != 1);
    end
    for (int s = 0; s < 7; s++) begin
      v = 32'(s << 4 | (s % 4) << 2);
      wr(12'h004, v);
      rd(12'h004, v);
      chk(ctrlOut.sweepBits, 32'(8 << s));
      chk({ctrlOut.forcedSearch, ctrlOut.quadrature}, {s[1], s % 4 == 1});
    end
    v = $urandom % 23;
    wr(12'h00C, v);
    rd(12'h00C, v);
    v = $urandom & 32'hFF;
    wr(12'h010, v);
    rd(12'h010, v);
    chk({ctrlOut.capUseFclk, ctrlOut.capDecim}, v);
    chk(capStb, v[7]);
    rd(12'h07C, 32'h0);
    chk(e, 1'b1);
    // Status bytes: a write is dropped, later bytes keep the first snapshot
    st <= dsdc_status_t'(88'({$urandom, $urandom, $urandom}));
    for (int g = 0; g < 5; g++) begin
      wr(base[g], 32'hFF);
      old = st;
      v = grp(old, g);
      for (int k = 0; k < nb[g]; k++) begin
        rd(base[g] + 12'(4 * k), {24'h0, v[8 * k +: 8]});
        st <= dsdc_status_t'(88'({$urandom, $urandom, $urandom}));
      end
    end
    for (int k = 0; k < 4; k++) begin
      st.codeLock <= k[0];
      despreadPower <= k[0];
      detectThreshold <= k[1];
      repeat (3) @(posedge clk_sys);
      chk({code_lock_probe, power_above_threshold_probe}, {k[0], k == 3});
    end
    // Gain rate over whole 32-chip runs; unlocked code slides per 8 bits
    st.codeLock <= 1'b0;
    wr(12'h004, 32'h0);
    for (int n = 0; n < 4; n++) begin
      wr(12'h00C, 32'(n));
      v = gainCount;
      run <= 1'b1;
      repeat (32) @(posedge clk_sys);
      run <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(gainCount - v, 32'(32 >> n));
    end
    chk(slideCount, 4);
    wr(12'h00C, 32'h10);
    wr(12'h010, 32'h2);
    wr(12'h004, 32'h4);
    capBase = capCount;
    v = $urandom;
    send(v[3:0], v[7:4]);
    wr(12'h008, 32'h1);
    send(v[11:8], v[15:12]);
    wr(12'h008, 32'h2);
    for (int k = 0; k < 8; k++)
      send({v[23 - k], 3'h5}, 4'h0);
    wr(12'h008, 32'h3);
    send(v[27:24], 4'h0);
    send(v[31:28], 4'h0);
    chk(connQ.size(), 3);
    chk(connQ[0][3:0], v[3:0]);
    chk(connQ[1][3:0], v[7:4]);
    chk(connQ[2], v[15:8]);
    chk(usbQ[0], v[23:16]);
    chk(usbQ[1], {v[27:24], v[31:28]});
    chk(capCount - capBase, 32'h4);
    final_report();
  end

  // Cuts a hung run short; the tests need about four hundred cycles
  initial begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule : test_dsdc_regbank
`default_nettype wire
